// ===== verilog/ecm_unit.sv
// Enhanced capture/compare/PWM unit with mode decode and Wishbone registers
`timescale 1ns/1ps
`default_nettype none

module ecm_unit (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 srst,
	// Wishbone slave
	input  wire ecm_pkg::ecm_wb_req_t wb_req,
	output logic                      wb_ack_ff,
	output logic [31:0]               wb_dat_ff,
	// Timer and converter
	input  wire logic [15:0]          timer_value,
	input  wire logic                 adc_enabled,
	output logic                      timer_clear_ff,
	output logic                      adc_start_ff,
	// Pins
	input  wire logic                 capture_in,
	output ecm_pkg::ecm_bridge_t      bridge_out_ff,
	// Interrupt
	output logic                      irq_ff
);
	import ecm_pkg::*;

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [3:0]             unit_mode_field;
	logic [1:0]             duty_lsb_ff;
	logic [7:0]             duty_high_byte;
	logic [15:0]            cmp_ff;
	logic [7:0]             period_ff;
	logic [15:0]            capt_ff;
	logic [ECM_NUM_EVT-1:0] status_ff;
	logic [ECM_NUM_EVT-1:0] mask_ff;
	logic [3:0]             mode_prev_ff;
	logic                   cmp_out_ff;
	logic                   match_prev_ff;

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	logic                   wr_en;
	logic                   rd_en;
	logic                   unit_off;
	logic                   mode_chg;
	logic                   is_cap;
	logic                   is_cmp;
	logic                   is_pwm;
	logic                   match_lvl;
	logic                   match_evt;
	logic                   cap_evt;
	logic                   pwm_raw;
	logic [9:0]             duty10;
	logic [ECM_NUM_EVT-1:0] evt_set;
	logic [ECM_NUM_EVT-1:0] w1c;
	logic [31:0]            rd_mux;
	logic [31:0]            wmask;
	ecm_bridge_t            nxt_bridge;

	assign wr_en = wb_req.cyc && wb_req.stb && wb_req.we && wb_ack_ff;
	assign rd_en = wb_req.cyc && wb_req.stb && !wb_ack_ff;

	// Byte-lane mask from select lines
	assign wmask = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}},
		{8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};

	// Reserved codes decode to no function at all
	assign is_cap   = ecm_is_capture(unit_mode_field);
	assign is_cmp   = ecm_is_compare(unit_mode_field);
	assign is_pwm   = ecm_is_pwm(unit_mode_field);
	assign unit_off = !(is_cap || is_cmp || is_pwm);
	assign mode_chg = unit_mode_field != mode_prev_ff;

	assign duty10 = {duty_high_byte, duty_lsb_ff};

	// ---------------------------------------------------------------
	// Wishbone slave: ack one cycle after the strobe
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			wb_ack_ff <= 1'b0;
		end else begin
			wb_ack_ff <= wb_req.cyc && wb_req.stb && !wb_ack_ff;
		end
	end

	// Unmapped offsets acknowledge and read as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (wb_req.adr)
			ECM_OFS_CTRL:    rd_mux[5:0] = {duty_lsb_ff, unit_mode_field};
			ECM_OFS_DUTY_HI: rd_mux[7:0] = duty_high_byte;
			ECM_OFS_CMP:     rd_mux[15:0] = cmp_ff;
			ECM_OFS_PERIOD:  rd_mux[7:0] = period_ff;
			ECM_OFS_CAPT:    rd_mux[15:0] = capt_ff;
			ECM_OFS_STATUS:  rd_mux[ECM_NUM_EVT-1:0] = status_ff;
			ECM_OFS_MASK:    rd_mux[ECM_NUM_EVT-1:0] = mask_ff;
			ECM_OFS_STATE:   rd_mux[4:0] = {cmp_out_ff, bridge_out_ff};
			default:         rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wb_dat_ff <= 32'h0000_0000;
		end else if (rd_en) begin
			wb_dat_ff <= rd_mux;
		end
	end

	// ---------------------------------------------------------------
	// Control register
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			unit_mode_field <= ECM_M_OFF;
			duty_lsb_ff     <= 2'b00;
		end else if (wr_en && wb_req.adr == ECM_OFS_CTRL && wb_req.sel[0]) begin
			unit_mode_field <= wb_req.dat[ECM_MODE_LSB +: 4];
			duty_lsb_ff     <= wb_req.dat[ECM_DCLSB_LSB +: 2];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			mode_prev_ff <= ECM_M_OFF;
		end else begin
			mode_prev_ff <= unit_mode_field;
		end
	end

	// ---------------------------------------------------------------
	// Duty, compare and period registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			duty_high_byte <= 8'h00;
		end else if (wr_en && wb_req.adr == ECM_OFS_DUTY_HI && wb_req.sel[0]) begin
			duty_high_byte <= wb_req.dat[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cmp_ff <= 16'h0000;
		end else if (wr_en && wb_req.adr == ECM_OFS_CMP) begin
			cmp_ff <= (cmp_ff & ~wmask[15:0]) | (wb_req.dat[15:0] & wmask[15:0]);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			period_ff <= ECM_PERIOD_RST;
		end else if (wr_en && wb_req.adr == ECM_OFS_PERIOD && wb_req.sel[0]) begin
			period_ff <= wb_req.dat[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			mask_ff <= '0;
		end else if (wr_en && wb_req.adr == ECM_OFS_MASK && wb_req.sel[0]) begin
			mask_ff <= wb_req.dat[ECM_NUM_EVT-1:0];
		end
	end

	// ---------------------------------------------------------------
	// Capture path
	// ---------------------------------------------------------------
	ecm_capture u_capture (
		.clk     (clk),
		.srst    (srst),
		.clear   (!is_cap || mode_chg),
		.mode    (unit_mode_field),
		.cap_pin (capture_in),
		.cap_evt (cap_evt)
	);

	always_ff @(posedge clk) begin
		if (srst) begin
			capt_ff <= 16'h0000;
		end else if (is_cap && cap_evt) begin
			capt_ff <= timer_value;
		end
	end

	// ---------------------------------------------------------------
	// Compare path: one event per match, on its first cycle
	// ---------------------------------------------------------------
	assign match_lvl = is_cmp && (timer_value == cmp_ff);
	assign match_evt = match_lvl && !match_prev_ff;

	always_ff @(posedge clk) begin
		if (srst) begin
			match_prev_ff <= 1'b0;
		end else begin
			match_prev_ff <= match_lvl;
		end
	end

	// Output held low whenever the unit is off or reserved
	always_ff @(posedge clk) begin
		if (srst || unit_off) begin
			cmp_out_ff <= 1'b0;
		end else if (!is_cmp) begin
			cmp_out_ff <= 1'b0;
		end else if (match_evt) begin
			case (unit_mode_field)
				ECM_M_CMP_TGL: cmp_out_ff <= !cmp_out_ff;
				ECM_M_CMP_SET: cmp_out_ff <= 1'b1;
				ECM_M_CMP_CLR: cmp_out_ff <= 1'b0;
				default:       cmp_out_ff <= cmp_out_ff;
			endcase
		end
	end

	// Special event: timer reset and conversion start are one-cycle pulses
	always_ff @(posedge clk) begin
		if (srst) begin
			timer_clear_ff <= 1'b0;
			adc_start_ff   <= 1'b0;
		end else begin
			timer_clear_ff <= match_evt && unit_mode_field == ECM_M_CMP_SPE;
			adc_start_ff   <= match_evt && unit_mode_field == ECM_M_CMP_SPE && adc_enabled;
		end
	end

	// ---------------------------------------------------------------
	// PWM path
	// ---------------------------------------------------------------
	ecm_pwm u_pwm (
		.clk     (clk),
		.srst    (srst),
		.en      (is_pwm),
		.period  (period_ff),
		.duty    (duty10),
		.pwm_raw (pwm_raw)
	);

	// Steering modes left out: all four pins carry pwm_raw, a and c inverted in LH and LL, b and d inverted in HL and LL
	always_comb begin
		nxt_bridge = '0;
		case (unit_mode_field)
			ECM_M_PWM_HH: nxt_bridge = {pwm_raw, pwm_raw, pwm_raw, pwm_raw};
			ECM_M_PWM_HL: nxt_bridge = {pwm_raw, !pwm_raw, pwm_raw, !pwm_raw};
			ECM_M_PWM_LH: nxt_bridge = {!pwm_raw, pwm_raw, !pwm_raw, pwm_raw};
			ECM_M_PWM_LL: nxt_bridge = {!pwm_raw, !pwm_raw, !pwm_raw, !pwm_raw};
			default: begin
				if (is_cmp) begin
					nxt_bridge.a = cmp_out_ff;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst || unit_off) begin
			bridge_out_ff <= '0;
		end else begin
			bridge_out_ff <= nxt_bridge;
		end
	end

	// ---------------------------------------------------------------
	// Status, mask and interrupt
	// ---------------------------------------------------------------
	always_comb begin
		evt_set              = '0;
		evt_set[ECM_ST_FLAG] = (is_cap && cap_evt) || match_evt;
		evt_set[ECM_ST_SPEC] = match_evt && unit_mode_field == ECM_M_CMP_SPE;
	end

	assign w1c = (wr_en && wb_req.adr == ECM_OFS_STATUS && wb_req.sel[0]) ?
		wb_req.dat[ECM_NUM_EVT-1:0] : '0;

	// A new event in the clearing cycle wins over the clear
	always_ff @(posedge clk) begin
		if (srst) begin
			status_ff <= '0;
		end else begin
			status_ff <= (status_ff & ~w1c) | evt_set;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(((status_ff & ~w1c) | evt_set) & mask_ff);
		end
	end

endmodule : ecm_unit
`default_nettype wire

// ===== verilog/ecm_pkg.sv
// Package for the enhanced capture/compare/PWM mode decode block
package ecm_pkg;

	// ---------------------------------------------------------------
	// Register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] ECM_OFS_CTRL    = 8'h00;
	localparam logic [7:0] ECM_OFS_DUTY_HI = 8'h04;
	localparam logic [7:0] ECM_OFS_CMP     = 8'h08;
	localparam logic [7:0] ECM_OFS_PERIOD  = 8'h0C;
	localparam logic [7:0] ECM_OFS_CAPT    = 8'h10;
	localparam logic [7:0] ECM_OFS_STATUS  = 8'h14;
	localparam logic [7:0] ECM_OFS_MASK    = 8'h18;
	localparam logic [7:0] ECM_OFS_STATE   = 8'h1C;

	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int         ECM_MODE_LSB    = 0;
	localparam int         ECM_DCLSB_LSB   = 4;
	localparam int         ECM_ST_FLAG     = 0;
	localparam int         ECM_ST_SPEC     = 1;
	localparam int         ECM_NUM_EVT     = 2;
	localparam logic [7:0] ECM_PERIOD_RST  = 8'hFF;

	// ---------------------------------------------------------------
	// Mode codes
	// ---------------------------------------------------------------
	localparam logic [3:0] ECM_M_OFF     = 4'h0;
	localparam logic [3:0] ECM_M_CMP_TGL = 4'h2;
	localparam logic [3:0] ECM_M_CAP_FE  = 4'h4;
	localparam logic [3:0] ECM_M_CAP_RE  = 4'h5;
	localparam logic [3:0] ECM_M_CAP_R4  = 4'h6;
	localparam logic [3:0] ECM_M_CAP_R16 = 4'h7;
	localparam logic [3:0] ECM_M_CMP_SET = 4'h8;
	localparam logic [3:0] ECM_M_CMP_CLR = 4'h9;
	localparam logic [3:0] ECM_M_CMP_SWI = 4'hA;
	localparam logic [3:0] ECM_M_CMP_SPE = 4'hB;
	localparam logic [3:0] ECM_M_PWM_HH  = 4'hC;
	localparam logic [3:0] ECM_M_PWM_HL  = 4'hD;
	localparam logic [3:0] ECM_M_PWM_LH  = 4'hE;
	localparam logic [3:0] ECM_M_PWM_LL  = 4'hF;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} ecm_wb_req_t;

	typedef struct packed {
		logic a;
		logic b;
		logic c;
		logic d;
	} ecm_bridge_t;

	// ---------------------------------------------------------------
	// Mode decode
	// ---------------------------------------------------------------
	function automatic logic ecm_is_capture(input logic [3:0] m);
		return m[3:2] == 2'b01;
	endfunction : ecm_is_capture

	function automatic logic ecm_is_compare(input logic [3:0] m);
		return (m[3:2] == 2'b10) || (m == ECM_M_CMP_TGL);
	endfunction : ecm_is_compare

	function automatic logic ecm_is_pwm(input logic [3:0] m);
		return m[3:2] == 2'b11;
	endfunction : ecm_is_pwm

endpackage : ecm_pkg

// ===== verilog/ecm_capture.sv
// Capture pin synchroniser, edge selection and edge prescaler
`timescale 1ns/1ps
`default_nettype none

module ecm_capture (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// Control
	input  wire logic       clear,
	input  wire logic [3:0] mode,
	// Pin and event
	input  wire logic       cap_pin,
	output logic            cap_evt
);
	import ecm_pkg::*;

	logic       sync1_ff;
	logic       sync2_ff;
	logic       prev_ff;
	logic [3:0] pre_ff;
	logic       rise;
	logic       fall;
	logic [3:0] last;

	always_ff @(posedge clk) begin
		sync1_ff <= cap_pin;
		sync2_ff <= sync1_ff;
		prev_ff  <= sync2_ff;
	end

	assign rise = sync2_ff & ~prev_ff;
	assign fall = ~sync2_ff & prev_ff;
	// Terminal count of the prescaler
	assign last = (mode == ECM_M_CAP_R16) ? 4'hF : 4'h3;

	// Prescaler cleared with the unit so a mode change starts a fresh count
	always_ff @(posedge clk) begin
		if (srst || clear) begin
			pre_ff <= 4'h0;
		end else if (rise && (mode == ECM_M_CAP_R4 || mode == ECM_M_CAP_R16)) begin
			pre_ff <= (pre_ff == last) ? 4'h0 : pre_ff + 4'h1;
		end
	end

	always_comb begin
		case (mode)
			ECM_M_CAP_FE:  cap_evt = fall;
			ECM_M_CAP_RE:  cap_evt = rise;
			ECM_M_CAP_R4:  cap_evt = rise && pre_ff == last;
			ECM_M_CAP_R16: cap_evt = rise && pre_ff == last;
			default:       cap_evt = 1'b0;
		endcase
	end

endmodule : ecm_capture
`default_nettype wire

// ===== verilog/ecm_pwm.sv
// Ten-bit PWM base: period counter and duty comparison
`timescale 1ns/1ps
`default_nettype none

module ecm_pwm (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// Control
	input  wire logic       en,
	input  wire logic [7:0] period,
	input  wire logic [9:0] duty,
	// Output
	output logic            pwm_raw
);
	logic [9:0] cnt_ff;
	logic [9:0] duty_ff;
	logic       wrap;

	assign wrap = cnt_ff == {period, 2'b11};

	// Duty latched only at wrap or while disabled, to avoid glitched periods
	always_ff @(posedge clk) begin
		if (srst || !en) begin
			cnt_ff  <= 10'h000;
			duty_ff <= duty;
		end else if (wrap) begin
			cnt_ff  <= 10'h000;
			duty_ff <= duty;
		end else begin
			cnt_ff <= cnt_ff + 10'h001;
		end
	end

	assign pwm_raw = en && (cnt_ff < duty_ff);

endmodule : ecm_pwm
`default_nettype wire

// ===== tb/ecm_monitor.sv
// Port-level assertions for the mode decode unit
`timescale 1ns/1ps
`default_nettype none
module ecm_monitor (
	// Clock and reset
	input wire logic                 clk,
	input wire logic                 srst,
	// Watched ports
	input wire ecm_pkg::ecm_wb_req_t wb_req,
	input wire logic                 wb_ack_ff,
	input wire logic [31:0]          wb_dat_ff,
	input wire logic                 adc_enabled,
	input wire logic                 timer_clear_ff,
	input wire logic                 adc_start_ff,
	input wire ecm_pkg::ecm_bridge_t bridge_out_ff,
	input wire logic                 irq_ff
);
	import ecm_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	// ----
	// Properties
	// ----
	sequence s_req;
		wb_req.cyc && wb_req.stb && !wb_ack_ff;
	endsequence
	sequence s_ack;
		wb_ack_ff ##1 !wb_ack_ff;
	endsequence
	property p_ack;
		s_req |=> s_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("ack did not pulse after request");
	property p_no_ack;
		!(wb_req.cyc && wb_req.stb) |=> !wb_ack_ff;
	endproperty
	a_no_ack: assert property (p_no_ack) else $error("ack without request");
	property p_unmapped;
		wb_ack_ff && !wb_req.we && wb_req.adr >= 8'h20 |-> wb_dat_ff == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_clr_pulse;
		timer_clear_ff |=> !timer_clear_ff;
	endproperty
	a_clr_pulse: assert property (p_clr_pulse) else $error("timer clear too long");
	property p_adc_clr;
		adc_start_ff |-> timer_clear_ff;
	endproperty
	a_adc_clr: assert property (p_adc_clr) else $error("start without timer clear");
	property p_adc_en;
		adc_start_ff |-> $past(adc_enabled);
	endproperty
	a_adc_en: assert property (p_adc_en) else $error("start while converter off");
	property p_rst_quiet;
		$past(srst) |-> !irq_ff && !wb_ack_ff && bridge_out_ff == 4'h0 && !timer_clear_ff && !adc_start_ff;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
	property p_irq_fall;
		$fell(irq_ff) |-> $past(wb_ack_ff && wb_req.we) || $past(wb_ack_ff && wb_req.we, 2);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell without a write");
endmodule : ecm_monitor
`default_nettype wire

// ===== tb/ecm_timer_model.sv
// Timer partner: free counter with wrap, cleared by the special event
`timescale 1ns/1ps
`default_nettype none
module ecm_timer_model #(
	parameter logic [15:0] TOP = 16'h003F
) (
	// Clock and reset
	input wire logic         clk,
	input wire logic         srst,
	// Event and count
	input wire logic         timer_clear_ff,
	output logic [15:0]      timer_value
);
	// Short wrap so compare matches recur often
	always_ff @(posedge clk) begin
		if (srst || timer_clear_ff || timer_value == TOP) begin
			timer_value <= 16'h0000;
		end else begin
			timer_value <= timer_value + 16'h0001;
		end
	end
endmodule : ecm_timer_model
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the mode decode unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ecm_pkg::*;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	ecm_wb_req_t wb_req = '0;
	logic        wb_ack_ff;
	logic [31:0] wb_dat_ff;
	logic [15:0] timer_value;
	logic        adc_enabled = 1'b0;
	logic        timer_clear_ff;
	logic        adc_start_ff;
	logic        capture_in = 1'b0;
	ecm_bridge_t bridge_out_ff;
	logic        irq_ff;
	int          mismatches = 0;
	int          checks_done = 0;
	int          n_clr = 0;
	int          n_adc = 0;
	int          cycles = 0;
	logic [31:0] seed = 32'h78161A2D;
	logic [31:0] d;
	logic [3:0]  cm [7] = '{4'h8, 4'hA, 4'h9, 4'h2, 4'h2, 4'hB, 4'hB};
	logic [1:0]  ca [7] = '{2'h1, 2'h1, 2'h0, 2'h1, 2'h0, 2'h2, 2'h2};
	ecm_unit i_dut (.clk(clk), .srst(srst), .wb_req(wb_req), .wb_ack_ff(wb_ack_ff), .wb_dat_ff(wb_dat_ff),
		.timer_value(timer_value), .adc_enabled(adc_enabled), .timer_clear_ff(timer_clear_ff),
		.adc_start_ff(adc_start_ff), .capture_in(capture_in), .bridge_out_ff(bridge_out_ff), .irq_ff(irq_ff));
	ecm_timer_model i_tmr (.clk(clk), .srst(srst), .timer_clear_ff(timer_clear_ff), .timer_value(timer_value));
	initial begin
		forever #20 clk = ~clk;
	end
	// Event counters and hang guard
	always @(posedge clk) begin
		cycles++;
		n_clr += (timer_clear_ff === 1'b1);
		n_adc += (adc_start_ff === 1'b1);
		if (cycles == 30000) begin
			mismatches++;
			stop_test();
		end
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function automatic logic [3:0] exp_br(input logic [3:0] m, input logic r);
		logic ac;
		logic bd;
		ac = r ^ (m == ECM_M_PWM_LH || m == ECM_M_PWM_LL);
		bd = r ^ (m == ECM_M_PWM_HL || m == ECM_M_PWM_LL);
		return {ac, bd, ac, bd};
	endfunction : exp_br
	// Single classic cycle; read data lands in d
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		@(posedge clk);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
		do @(posedge clk); while (wb_ack_ff !== 1'b1);
		d = wb_dat_ff;
		wb_req <= '0;
	endtask : wb
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		int c0;
		int a0;
		int n;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		wb(1'b0, ECM_OFS_PERIOD, 32'h0);
		chk("period", 32'hFF, d);
		wb(1'b0, ECM_OFS_CTRL, 32'h0);
		chk("ctrl", 32'h0, d);
		wb(1'b0, 8'h20, 32'h0);
		chk("unmapped", 32'h0, d);
		wb(1'b1, ECM_OFS_CTRL, 32'h3D);
		wb(1'b0, ECM_OFS_CTRL, 32'h0);
		chk("ctrl", 32'h3D, d);
		$display("register test done");
		// ----
		// Compare modes
		// ----
		wb(1'b1, ECM_OFS_MASK, 32'h1);
		wb(1'b1, ECM_OFS_CMP, 32'h8 + (xs() % 32'h38));
		for (int i = 0; i < 7; i++) begin
			c0 = n_clr;
			a0 = n_adc;
			adc_enabled <= (i == 5);
			wb(1'b1, ECM_OFS_CTRL, {28'h0, cm[i]});
			wb(1'b1, ECM_OFS_STATUS, 32'h3);
			repeat (3) @(posedge clk);
			n = 0;
			while (irq_ff !== 1'b1 && n < 200) begin
				@(posedge clk);
				n++;
			end
			repeat (3) @(posedge clk);
			chk("irq", 32'h1, irq_ff);
			if (ca[i] != 2'h2) chk("cmp_out", ca[i], bridge_out_ff.a);
			wb(1'b0, ECM_OFS_STATUS, 32'h0);
			chk("status", cm[i] == ECM_M_CMP_SPE ? 32'h3 : 32'h1, d);
			chk("clr_seen", (cm[i] == ECM_M_CMP_SPE), n_clr > c0);
			chk("adc_starts", i == 5 ? n_clr - c0 : 0, n_adc - a0);
		end
		for (int i = 1; i < 4; i += 2) begin
			c0 = n_clr;
			wb(1'b1, ECM_OFS_CTRL, i);
			wb(1'b1, ECM_OFS_STATUS, 32'h3);
			repeat (140) @(posedge clk);
			chk("rsv_irq", 32'h0, irq_ff);
			chk("rsv_bridge", 32'h0, bridge_out_ff);
			chk("rsv_clr", c0, n_clr);
		end
		wb(1'b1, ECM_OFS_MASK, 32'h0);
		wb(1'b1, ECM_OFS_CTRL, ECM_M_CMP_SET);
		repeat (140) @(posedge clk);
		chk("masked_irq", 32'h0, irq_ff);
		wb(1'b0, ECM_OFS_STATUS, 32'h0);
		chk("masked_flag", 32'h1, d[0]);
		wb(1'b1, ECM_OFS_STATUS, 32'h3);
		wb(1'b0, ECM_OFS_STATUS, 32'h0);
		chk("w1c", 32'h0, d[0]);
		$display("compare test done");
		// ----
		// PWM polarity and duty low bits
		// ----
		wb(1'b1, ECM_OFS_PERIOD, 32'h0);
		for (int i = 0; i < 4; i++) begin
			for (int r = 0; r < 2; r++) begin
				wb(1'b1, ECM_OFS_DUTY_HI, r ? 32'hFF : 32'h0);
				wb(1'b1, ECM_OFS_CTRL, {26'h0, r ? 2'h3 : 2'h0, ECM_M_PWM_HH + 4'(i)});
				repeat (20) @(posedge clk);
				chk("bridge", exp_br(ECM_M_PWM_HH + 4'(i), r), bridge_out_ff);
			end
		end
		wb(1'b1, ECM_OFS_DUTY_HI, 32'h0);
		for (int k = 1; k < 4; k++) begin
			wb(1'b1, ECM_OFS_CTRL, {26'h0, 2'(k), ECM_M_PWM_HH});
			repeat (20) @(posedge clk);
			n = 0;
			repeat (40) begin
				@(posedge clk);
				n += (bridge_out_ff.a === 1'b1);
			end
			chk("duty_hi_cycles", 10 * k, n);
		end
		wb(1'b1, ECM_OFS_CTRL, ECM_M_OFF);
		repeat (4) @(posedge clk);
		chk("off_bridge", 32'h0, bridge_out_ff);
		$display("pwm test done");
		// ----
		// Capture edges and prescaler
		// ----
		wb(1'b1, ECM_OFS_CTRL, ECM_M_CAP_FE);
		wb(1'b1, ECM_OFS_STATUS, 32'h3);
		capture_in <= 1'b1;
		repeat (8) @(posedge clk);
		wb(1'b0, ECM_OFS_STATUS, 32'h0);
		chk("fe_on_rise", 32'h0, d[0]);
		capture_in <= 1'b0;
		repeat (8) @(posedge clk);
		wb(1'b0, ECM_OFS_STATUS, 32'h0);
		chk("fe_on_fall", 32'h1, d[0]);
		wb(1'b1, ECM_OFS_CTRL, ECM_M_CAP_RE);
		wb(1'b1, ECM_OFS_STATUS, 32'h3);
		// Two sync flops and the edge detect put the capture three edges on
		c0 = (timer_value + 3) % 64;
		capture_in <= 1'b1;
		repeat (8) @(posedge clk);
		wb(1'b0, ECM_OFS_STATUS, 32'h0);
		chk("re_on_rise", 32'h1, d[0]);
		wb(1'b0, ECM_OFS_CAPT, 32'h0);
		chk("capt_value", c0, d);
		capture_in <= 1'b0;
		for (int j = 0; j < 4; j++) begin
			c0 = j[1] ? 16 : 4;
			n = j[0] ? 1 + (xs() % 20) : c0 - 1;
			wb(1'b1, ECM_OFS_CTRL, ECM_M_OFF);
			wb(1'b1, ECM_OFS_CTRL, j[1] ? ECM_M_CAP_R16 : ECM_M_CAP_R4);
			wb(1'b1, ECM_OFS_STATUS, 32'h3);
			repeat (n) begin
				capture_in <= 1'b1;
				repeat (3) @(posedge clk);
				capture_in <= 1'b0;
				repeat (3) @(posedge clk);
			end
			repeat (8) @(posedge clk);
			wb(1'b0, ECM_OFS_STATUS, 32'h0);
			chk("prescaled", n >= c0, d[0]);
		end
		$display("capture test done");
		stop_test();
	end
endmodule : tb_top
bind ecm_unit ecm_monitor i_mon (.clk(clk), .srst(srst), .wb_req(wb_req), .wb_ack_ff(wb_ack_ff),
	.wb_dat_ff(wb_dat_ff), .adc_enabled(adc_enabled), .timer_clear_ff(timer_clear_ff),
	.adc_start_ff(adc_start_ff), .bridge_out_ff(bridge_out_ff), .irq_ff(irq_ff));
`default_nettype wire
